// *** src/oec_clkout.sv ***
//******************************************************************
// oscillator enable and clock out: apb slave and two dividers
//******************************************************************
// Purpose: oscillator enables and two divided clock outputs
// Assumes: oscillator inputs are synchronous to pclk and slower than pclk/2
// Notes:   every output comes from a flip-flop
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "oec_defs.svh"

module oec_clkout (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // oscillators and system clock source
   input  wire logic        hs_internal_osc,
   input  wire logic        low_speed_osc,
   input  wire logic        hs_crystal_osc,
   input  wire logic [1:0]  system_clock_source,
   // oscillator enables
   output logic             hs_internal_osc_enable,
   output logic             low_speed_osc_enable,
   output logic             hs_crystal_osc_enable,
   // clock out pins
   output logic             clock_out_a,
   output logic             clock_out_b
);

   //******************************************************************
   // helpers
   //******************************************************************
   function automatic oec_pkg::oec_sel_t decode(input logic [31:0] addr);
      if (addr == {14'h0000, `OEC_IDX_OSC_CTL, 2'b00}) begin
         decode = oec_pkg::OEC_SEL_OSC;
      end else if (addr == {14'h0000, `OEC_IDX_OUT_A, 2'b00}) begin
         decode = oec_pkg::OEC_SEL_OUT_A;
      end else if (addr == {14'h0000, `OEC_IDX_OUT_B, 2'b00}) begin
         decode = oec_pkg::OEC_SEL_OUT_B;
      end else begin
         decode = oec_pkg::OEC_SEL_NONE;
      end
   endfunction

   function automatic logic osc_pick(input logic [1:0] src, input logic hsi,
                                     input logic ls, input logic hsx);
      // reserved code gives a quiet source, never garbage
      case (src)
         `OEC_SRC_HSI: osc_pick = hsi;
         `OEC_SRC_LS:  osc_pick = ls;
         `OEC_SRC_HSX: osc_pick = hsx;
         default:      osc_pick = 1'b0;
      endcase
   endfunction

   function automatic oec_pkg::oec_chan_cfg_t chan_wr(input logic [31:0] d);
      chan_wr.div = d[`OEC_DIV_MSB:`OEC_DIV_LSB];
      chan_wr.src = d[`OEC_SRC_MSB:`OEC_SRC_LSB];
      chan_wr.en  = d[`OEC_EN_BIT];
   endfunction

   function automatic logic [31:0] chan_rd(input oec_pkg::oec_chan_cfg_t c);
      chan_rd = {24'h000000, 1'b0, c.div, c.src, 1'b0, c.en};
   endfunction

   //******************************************************************
   // state
   //******************************************************************
   oec_pkg::oec_osc_en_t   osc_en;
   oec_pkg::oec_osc_en_t   next_osc_en;
   oec_pkg::oec_chan_cfg_t cfg      [2];
   oec_pkg::oec_chan_cfg_t next_cfg [2];
   oec_pkg::oec_chan_cfg_t act      [2];
   oec_pkg::oec_chan_cfg_t next_act [2];
   logic [`OEC_CNT_W-1:0]  cnt      [2];
   logic [`OEC_CNT_W-1:0]  next_cnt [2];
   logic                   smp      [2];
   logic                   next_smp [2];
   logic                   prv      [2];
   logic                   next_prv [2];
   logic                   out      [2];
   logic                   next_out [2];
   logic [31:0]            next_prdata;
   logic                   next_pready;
   logic                   next_pslverr;
   oec_pkg::oec_sel_t      sel;
   logic                   commit;
   logic                   rise     [2];

   //******************************************************************
   // apb slave and register writes
   //******************************************************************
   always_comb begin
      sel          = decode(paddr);
      next_pready  = psel & penable & ~pready;
      next_pslverr = psel & penable & ~pready & (sel == oec_pkg::OEC_SEL_NONE);
      commit       = psel & penable & pready & pwrite & ~pslverr;
      next_prdata  = 32'h00000000;
      if (psel & penable & ~pready & ~pwrite) begin
         // [R11] reserved bits read zero
         if (sel == oec_pkg::OEC_SEL_OSC) begin
            next_prdata = {29'h00000000, osc_en};
         end else if (sel == oec_pkg::OEC_SEL_OUT_A) begin
            next_prdata = chan_rd(cfg[0]);
         end else if (sel == oec_pkg::OEC_SEL_OUT_B) begin
            next_prdata = chan_rd(cfg[1]);
         end
      end
      next_osc_en = osc_en;
      next_cfg[0] = cfg[0];
      next_cfg[1] = cfg[1];
      if (commit && sel == oec_pkg::OEC_SEL_OSC) begin
         // [R01] internal stop refused
         next_osc_en.hsi = pwdata[`OEC_HSI_BIT]
                           | (osc_en.hsi & (system_clock_source == `OEC_SRC_HSI));
         // [R02] low-speed stop refused
         next_osc_en.ls  = pwdata[`OEC_LS_BIT]
                           | (osc_en.ls & (system_clock_source == `OEC_SRC_LS));
         // [R04] crystal stop refused
         next_osc_en.hsx = pwdata[`OEC_HSX_BIT]
                           | (osc_en.hsx & (system_clock_source == `OEC_SRC_HSX));
      end
      if (commit && sel == oec_pkg::OEC_SEL_OUT_A) begin
         next_cfg[0] = chan_wr(pwdata);
      end
      // [R10] channel b enable writable
      if (commit && sel == oec_pkg::OEC_SEL_OUT_B) begin
         next_cfg[1] = chan_wr(pwdata);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         // [R01] internal runs from reset
         osc_en  <= `OEC_OSC_CTL_RST;
         cfg[0]  <= `OEC_OUT_RST;
         cfg[1]  <= `OEC_OUT_RST;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
         osc_en  <= next_osc_en;
         cfg[0]  <= next_cfg[0];
         cfg[1]  <= next_cfg[1];
      end
   end

   assign hs_internal_osc_enable = osc_en.hsi;
   assign low_speed_osc_enable   = osc_en.ls;
   assign hs_crystal_osc_enable  = osc_en.hsx;

   //******************************************************************
   // clock out dividers
   //******************************************************************
   // new settings wait for a low output; a trade of a little latency for clean pins
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         // [R06] [R09] source pick
         next_smp[i] = osc_pick(act[i].src, hs_internal_osc, low_speed_osc, hs_crystal_osc);
         next_prv[i] = smp[i];
         rise[i]     = smp[i] & ~prv[i];
         next_act[i] = act[i];
         next_cnt[i] = cnt[i];
         next_out[i] = 1'b0;
         // [R13] switch only while low
         if (!out[i] && act[i] != cfg[i]) begin
            next_act[i] = cfg[i];
            next_cnt[i] = '0;
         end else if (act[i].en) begin
            if (rise[i]) begin
               next_cnt[i] = cnt[i] + 7'h01;
            end
            // [R05] [R08] power of two ratio
            if (act[i].div == 3'h0) begin
               next_out[i] = smp[i];
            end else begin
               next_out[i] = next_cnt[i][act[i].div - 3'h1];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 2; i++) begin
            act[i] <= `OEC_OUT_RST;
            cnt[i] <= '0;
            smp[i] <= 1'b0;
            prv[i] <= 1'b0;
            out[i] <= 1'b0;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            act[i] <= next_act[i];
            cnt[i] <= next_cnt[i];
            smp[i] <= next_smp[i];
            prv[i] <= next_prv[i];
            out[i] <= next_out[i];
         end
      end
   end

   // [R07] [R12] pins follow enabled dividers
   assign clock_out_a = out[0];
   assign clock_out_b = out[1];

   //******************************************************************
   // assertions
   //******************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_osc_write;
      psel && penable && pready && pwrite && !pslverr && sel == oec_pkg::OEC_SEL_OSC;
   endsequence

   sequence s_access_wait;
      psel && penable && !pready;
   endsequence

   sequence s_cha_write;
      psel && penable && pready && pwrite && !pslverr && sel == oec_pkg::OEC_SEL_OUT_A;
   endsequence

   sequence s_chb_write;
      psel && penable && pready && pwrite && !pslverr && sel == oec_pkg::OEC_SEL_OUT_B;
   endsequence

   sequence s_err_done;
      psel && penable && pready && pslverr;
   endsequence

   a_hsi_stop_hold: assert property ( // [R01]
      s_osc_write and (system_clock_source == `OEC_SRC_HSI && osc_en.hsi)
      |=> hs_internal_osc_enable)
      else $error("internal oscillator stopped while system clock");

   a_ls_stop_hold: assert property ( // [R02]
      s_osc_write and (system_clock_source == `OEC_SRC_LS && osc_en.ls)
      |=> low_speed_osc_enable)
      else $error("low-speed oscillator stopped while system clock");

   a_hsx_stop_hold: assert property ( // [R04]
      s_osc_write and (system_clock_source == `OEC_SRC_HSX && osc_en.hsx)
      |=> hs_crystal_osc_enable)
      else $error("crystal oscillator stopped while system clock");

   a_hsx_write_take: assert property ( // [R04]
      s_osc_write and (system_clock_source != `OEC_SRC_HSX)
      |=> hs_crystal_osc_enable == $past(pwdata[`OEC_HSX_BIT]))
      else $error("crystal enable did not take write");

   a_rsvd_read_zero: assert property ( // [R11]
      s_access_wait and (!pwrite && sel != oec_pkg::OEC_SEL_OSC)
      |=> pready && prdata[7] == 1'b0 && prdata[1] == 1'b0 && prdata[31:8] == 24'h0)
      else $error("reserved channel bits read nonzero");

   a_out_a_off: assert property ( // [R07]
      !act[0].en |=> !clock_out_a)
      else $error("channel a output high while disabled");

   a_out_b_off: assert property ( // [R12]
      !act[1].en |=> !clock_out_b)
      else $error("channel b output high while disabled");

   a_switch_low_only: assert property ( // [R13]
      (act[0] != $past(act[0])) |-> $past(clock_out_a, 2) == 1'b0 || $past(out[0]) == 1'b0)
      else $error("channel a switched while output high");

   a_div_max_rise: assert property ( // [R05]
      act[0].en && act[0].div == `OEC_DIV_MAX && $stable(act[0]) && $rose(clock_out_a)
      |-> $past(cnt[0]) == 7'h3f && $past(rise[0]))
      else $error("channel a top ratio edge misplaced");

   a_src_ls_pick: assert property ( // [R09]
      act[1].src == `OEC_SRC_LS && $stable(act[1]) |-> smp[1] == $past(low_speed_osc))
      else $error("channel b low-speed source not sampled");

   a_apb_one_wait: assert property (
      s_access_wait |=> pready ##1 !pready)
      else $error("apb answer not one wait state");

   a_hsi_write_take: assert property ( // [R01]
      s_osc_write and (system_clock_source != `OEC_SRC_HSI)
      |=> hs_internal_osc_enable == $past(pwdata[`OEC_HSI_BIT]))
      else $error("internal enable did not take write");

   a_ls_write_take: assert property ( // [R02]
      s_osc_write and (system_clock_source != `OEC_SRC_LS)
      |=> low_speed_osc_enable == $past(pwdata[`OEC_LS_BIT]))
      else $error("low-speed enable did not take write");

   a_cha_write_take: assert property ( // [R05]
      s_cha_write |=> cfg[0] == {$past(pwdata[`OEC_DIV_MSB:`OEC_DIV_LSB]),
         $past(pwdata[`OEC_SRC_MSB:`OEC_SRC_LSB]), $past(pwdata[`OEC_EN_BIT])})
      else $error("channel a register did not take write");

   a_chb_write_take: assert property ( // [R10]
      s_chb_write |=> cfg[1] == {$past(pwdata[`OEC_DIV_MSB:`OEC_DIV_LSB]),
         $past(pwdata[`OEC_SRC_MSB:`OEC_SRC_LSB]), $past(pwdata[`OEC_EN_BIT])})
      else $error("channel b register did not take write");

   a_err_no_write: assert property (
      s_err_done |=> $stable(osc_en) && $stable(cfg[0]) && $stable(cfg[1]))
      else $error("unmapped access changed a register");

   a_err_with_ready: assert property (
      pslverr |-> pready)
      else $error("error response without ready");

   a_prdata_idle: assert property (
      !pready |-> prdata == 32'h00000000)
      else $error("read data not zero outside answer");

   a_src_quiet_a: assert property ( // [R06]
      act[0].src == 2'h3 |=> !smp[0])
      else $error("channel a reserved source not quiet");

   a_src_quiet_b: assert property ( // [R09]
      act[1].src == 2'h3 |=> !smp[1])
      else $error("channel b reserved source not quiet");

   a_div_one_a: assert property ( // [R05]
      act[0].en && act[0].div == 3'h0 && act[0] == cfg[0] |=> clock_out_a == $past(smp[0]))
      else $error("channel a ratio one does not follow source");

   a_div_one_b: assert property ( // [R08]
      act[1].en && act[1].div == 3'h0 && act[1] == cfg[1] |=> clock_out_b == $past(smp[1]))
      else $error("channel b ratio one does not follow source");

   a_switch_low_b: assert property ( // [R13]
      (act[1] != $past(act[1])) |-> $past(out[1]) == 1'b0)
      else $error("channel b switched while output high");

   a_cnt_switch_zero: assert property ( // [R13]
      (act[0] != $past(act[0])) |-> cnt[0] == 7'h00)
      else $error("channel a counter not restarted on switch");

   a_osc_rsvd_zero: assert property (
      s_access_wait and (!pwrite && sel == oec_pkg::OEC_SEL_OSC)
      |=> pready && prdata[31:3] == 29'h00000000)
      else $error("reserved oscillator bits read nonzero");

endmodule

// *** src/oec_defs.svh ***
//******************************************************************
// oscillator enable and clock out: constants
//******************************************************************
// Purpose: offsets, field positions, reset values and codes of the block
// Assumes: apb byte address is four times the register index
// Notes:   included by oec_clkout.sv and by the bench
//
// Overview of operation
// [R01] internal high-speed enable resets to 1; clearing refused while it feeds system clock
// [R02] low-speed enable resets to 0; clearing refused while it feeds system clock
// [R03] software picks the low-speed source before it sets the low-speed enable
// [R04] crystal enable resets to 0; clearing refused while it feeds system clock
// [R05] channel a divides its source by two to the power of bits 6..4
// [R06] channel a bits 3..2 pick internal, low-speed or crystal; code 3 gives nothing
// [R07] channel a enable at bit 0 drives the divided clock out; 0 stops it
// [R08] channel b divides its source by two to the power of bits 6..4
// [R09] channel b bits 3..2 pick internal, low-speed or crystal; code 3 gives nothing
// [R10] channel b bit 0 is a read/write output enable that resets to 0
// [R11] bits 7 and 1 of both channel registers always read as zero
// [R12] channel b enable at 1 drives its divided clock out; 0 stops it
// [R13] outputs switch only while low, so no runt pulses; pin low when disabled; at ratio codes 0 and 1 the first high after a switch can be short
`ifndef OEC_DEFS_SVH
`define OEC_DEFS_SVH

// register indices, byte address is index times four
`define OEC_IDX_OSC_CTL   16'h5061
`define OEC_IDX_OUT_A     16'h5064
`define OEC_IDX_OUT_B     16'h5065

// oscillator enable register fields
`define OEC_HSI_BIT       2
`define OEC_LS_BIT        1
`define OEC_HSX_BIT       0
`define OEC_OSC_CTL_RST   3'h4

// clock out register fields
`define OEC_DIV_MSB       6
`define OEC_DIV_LSB       4
`define OEC_SRC_MSB       3
`define OEC_SRC_LSB       2
`define OEC_EN_BIT        0
`define OEC_OUT_RST       6'h00

// source codes, shared with the system clock source input
`define OEC_SRC_HSI       2'h0
`define OEC_SRC_LS        2'h1
`define OEC_SRC_HSX       2'h2

// divider width and the top ratio code
`define OEC_CNT_W         7
`define OEC_DIV_MAX       3'h7

`endif

// *** src/oec_pkg.sv ***
//******************************************************************
// oscillator enable and clock out: types
//******************************************************************
// Purpose: packed carriers for the register contents
// Assumes: nothing
// Notes:   constants live in oec_defs.svh
package oec_pkg;

   typedef struct packed {
      logic hsi;
      logic ls;
      logic hsx;
   } oec_osc_en_t;

   typedef struct packed {
      logic [2:0] div;
      logic [1:0] src;
      logic       en;
   } oec_chan_cfg_t;

   typedef enum logic [1:0] {
      OEC_SEL_OSC,
      OEC_SEL_OUT_A,
      OEC_SEL_OUT_B,
      OEC_SEL_NONE
   } oec_sel_t;

endpackage

// *** bench/oec_pin_watch.sv ***
//******************************************************************
// clock out receiver model
//******************************************************************
// Purpose: receiver on one clock out pin, measures one output period
// Assumes: pin comes from a flip-flop on pclk
// Notes:   first rise after arm is skipped, config may still settle
`timescale 1ns/1ps

module oec_pin_watch (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // pin and request
   input  wire logic        pin,
   input  wire logic        arm,
   output logic             done,
   output logic [15:0]      period
);
   logic        last;
   logic [1:0]  rises;
   logic [15:0] cnt;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last   <= 1'b0;
         rises  <= 2'h3;
         cnt    <= 16'h0;
         done   <= 1'b0;
         period <= 16'h0;
      end else begin
         done <= 1'b0;
         last <= pin;
         cnt  <= cnt + 16'h1;
         if (arm) begin
            rises <= 2'h0;
         end else if (pin && !last && rises != 2'h3) begin
            rises <= rises + 2'h1;
            cnt   <= 16'h1;
            if (rises == 2'h2) begin
               done   <= 1'b1;
               period <= cnt;
            end
         end
      end
   end
endmodule

// *** bench/oec_clkout_tb.sv ***
//******************************************************************
// oscillator enable and clock out bench
//******************************************************************
// Purpose: apb register checks and clock out periods on both channels
// Assumes: oscillator periods 4, 6 and 8 pclk cycles
// Notes:   reads and periods are checked from queues by watchers
`timescale 1ns/1ps
`include "oec_defs.svh"

module oec_clkout_tb;
   localparam logic [31:0] A_OSC = 32'({`OEC_IDX_OSC_CTL, 2'b00});
   localparam logic [31:0] A_CHA = 32'({`OEC_IDX_OUT_A, 2'b00});
   localparam logic [31:0] A_CHB = 32'({`OEC_IDX_OUT_B, 2'b00});
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r, a;
   logic        pready, pslverr, hsi = 1'b0, lso = 1'b0, hsx = 1'b0;
   logic [1:0]  sys_src = 2'h0, sv;
   logic [2:0]  dv;
   logic        hsi_en, ls_en, hsx_en, out_a, out_b, hi;
   logic        arm_a = 1'b0, arm_b = 1'b0, done_a, done_b;
   logic [15:0] per_a, per_b;
   logic [33:0] exp_q[$], e;
   logic [31:0] per_q[$];
   logic [31:0] seed = 32'h79b9fbec;
   int          bad_count = 0, check_count = 0, osc_cnt = 0;

   oec_clkout oec_clkout_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hs_internal_osc(hsi), .low_speed_osc(lso), .hs_crystal_osc(hsx),
      .system_clock_source(sys_src), .hs_internal_osc_enable(hsi_en),
      .low_speed_osc_enable(ls_en), .hs_crystal_osc_enable(hsx_en),
      .clock_out_a(out_a), .clock_out_b(out_b));
   oec_pin_watch oec_pin_watch_a (.pclk(pclk), .presetn(presetn), .pin(out_a), .arm(arm_a),
      .done(done_a), .period(per_a));
   oec_pin_watch oec_pin_watch_b (.pclk(pclk), .presetn(presetn), .pin(out_b), .arm(arm_b),
      .done(done_b), .period(per_b));

   //******************************************************************
   // clock, oscillators, helpers
   //******************************************************************
   always #2.5 pclk = ~pclk;

   // each level held at least two pclk cycles
   always @(posedge pclk) begin
      osc_cnt <= osc_cnt + 1;
      if (osc_cnt % 2 == 1) hsi <= ~hsi;
      if (osc_cnt % 3 == 2) lso <= ~lso;
      if (osc_cnt % 4 == 3) hsx <= ~hsx;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // master holds the request until pready is seen high
   task automatic apb(input logic wr, input logic [31:0] ad, input logic [31:0] d,
                      input logic err, input logic [31:0] rd);
      exp_q.push_back({~wr, err, rd});
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= ad;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic quiet(input logic ch);
      hi = 1'b0;
      repeat (64) begin
         @(posedge pclk);
         hi = hi | (ch ? out_b : out_a);
      end
   endtask

   //******************************************************************
   // watchers
   //******************************************************************
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check("pslverr", 32'(pslverr), 32'(e[32]));
         if (e[33]) check("prdata", prdata, e[31:0]);
      end
      if ((done_a || done_b) && per_q.size() > 0) begin
         check("period", 32'(done_a ? per_a : per_b), per_q.pop_front());
      end
   end

   initial begin
      #400000;
      check("watchdog", 32'h1, 32'h0);
      end_sim();
   end

   //******************************************************************
   // main sequence
   //******************************************************************
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, A_OSC, 32'h0, 1'b0, 32'h4);
      apb(1'b0, A_CHA, 32'h0, 1'b0, 32'h0);
      apb(1'b0, A_CHB, 32'h0, 1'b0, 32'h0);
      check("pins", 32'({out_a, out_b, hsi_en, ls_en, hsx_en}), 32'h4);
      apb(1'b1, A_OSC + 32'h4, xs(), 1'b1, 32'h0);
      apb(1'b0, A_OSC + 32'h4, 32'h0, 1'b1, 32'h0);
      for (int s = 0; s < 3; s++) begin
         sys_src <= 2'(s);
         apb(1'b1, A_OSC, 32'h7, 1'b0, 32'h0);
         apb(1'b1, A_OSC, 32'h0, 1'b0, 32'h0);
         apb(1'b0, A_OSC, 32'h0, 1'b0, 32'h1 << (2 - s));
         check("enables", 32'({hsi_en, ls_en, hsx_en}), 32'h1 << (2 - s));
      end
      sys_src <= 2'h0;
      for (int ch = 0; ch < 2; ch++) begin
         a = ch ? A_CHB : A_CHA;
         for (int n = 0; n < 8; n++) begin
            r  = xs();
            dv = 3'(n);
            sv = 2'(r[9:8] % 2'h3);
            apb(1'b1, a, {r[31:8], r[7], dv, sv, r[1], 1'b1}, 1'b0, 32'h0);
            apb(1'b0, a, 32'h0, 1'b0, {25'h0, dv, sv, 2'b01});
            per_q.push_back(32'((2 * (int'(sv) + 2)) << dv));
            arm_a <= (ch == 0);
            arm_b <= (ch == 1);
            @(posedge pclk);
            arm_a <= 1'b0;
            arm_b <= 1'b0;
            for (int w = 0; w < 4000 && per_q.size() > 0; w++) @(posedge pclk);
            check("period wait", 32'(per_q.size()), 32'h0);
            per_q.delete();
         end
         apb(1'b1, a, 32'h0, 1'b0, 32'h0);
         repeat (600) @(posedge pclk);
         quiet(1'(ch));
         check("disabled pin", 32'(hi), 32'h0);
         apb(1'b1, a, 32'h1d, 1'b0, 32'h0);
         quiet(1'(ch));
         check("reserved source pin", 32'(hi), 32'h0);
      end
      check("answers left", 32'(exp_q.size()), 32'h0);
      end_sim();
   end
endmodule
